// [logic/interrupt_priority_select_bank.sv]
// Module: bank of three interrupt priority select registers
`timescale 1ns/1ps

module interrupt_priority_select_bank
  import priority_select_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   parallel_slave_level,
  output logic                   converter_done_level,
  output logic                   serial_rx_level,
  output logic                   serial_tx_level,
  output logic                   sync_serial_level,
  output logic                   capture_unit_a_level,
  output logic                   timer2_match_level,
  output logic                   timer1_overflow_level,
  output logic                   comparator_level,
  output logic                   bus_collision_level,
  output logic                   low_voltage_level,
  output logic                   timer3_overflow_level,
  output logic                   capture_unit_b_level,
  output logic                   invalid_message_level,
  output logic                   bus_wakeup_level,
  output logic                   can_error_level,
  output logic                   tx_buffer_two_level,
  output logic                   tx_buffer_one_level,
  output logic                   tx_buffer_zero_level,
  output logic                   rx_buffer_one_level,
  output logic                   rx_buffer_zero_level
);

  // Stored priority bits
  logic [7:0] sel_a_ff;
  logic [7:0] sel_b_ff;
  logic [7:0] sel_c_ff;
  logic [7:0] nxt_sel_a;
  logic [7:0] nxt_sel_b;
  logic [7:0] nxt_sel_c;

  // Software view of each register
  logic [7:0] view_a;
  logic [7:0] view_b;
  logic [7:0] view_c;

  // Write data after the implemented-bit masks
  logic [7:0] wr_view_a;
  logic [7:0] wr_view_b;
  logic [7:0] wr_view_c;

  // Read path
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // Decoded accesses
  logic       hit_a;
  logic       hit_b;
  logic       hit_c;
  logic       wr_a;
  logic       wr_b;
  logic       wr_c;
  logic       rd_a;
  logic       rd_b;
  logic       rd_c;

  // Address decode; unmapped indices hit nothing
  always_comb begin
    hit_a = 1'b0;
    hit_b = 1'b0;
    hit_c = 1'b0;
    case (addr)
      ADDR_SEL_A: begin
        hit_a = 1'b1;
      end
      ADDR_SEL_B: begin
        hit_b = 1'b1;
      end
      ADDR_SEL_C: begin
        hit_c = 1'b1;
      end
      default: begin
        hit_a = 1'b0;
        hit_b = 1'b0;
        hit_c = 1'b0;
      end
    endcase
  end

  // Both strobes at once serve both; the read then returns the old value
  assign wr_a = wr_strobe & hit_a;
  assign wr_b = wr_strobe & hit_b;
  assign wr_c = wr_strobe & hit_c;
  assign rd_a = rd_strobe & hit_a;
  assign rd_b = rd_strobe & hit_b;
  assign rd_c = rd_strobe & hit_c;

  // Masks per bit, so an unimplemented flop can never leak out
  for (genvar i = 0; i < DATA_W; i++) begin : g_view
    assign view_a[i]    = sel_a_ff[i] & MASK_SEL_A[i];
    assign view_b[i]    = sel_b_ff[i] & MASK_SEL_B[i];
    assign view_c[i]    = sel_c_ff[i] & MASK_SEL_C[i];
    assign wr_view_a[i] = wr_data[i] & MASK_SEL_A[i];
    assign wr_view_b[i] = wr_data[i] & MASK_SEL_B[i];
    assign wr_view_c[i] = wr_data[i] & MASK_SEL_C[i];
  end

  // Register a: all eight bits implemented
  always_comb begin
    nxt_sel_a = sel_a_ff;
    if (wr_a) begin
      nxt_sel_a[POS_PARALLEL_SLAVE] = wr_view_a[POS_PARALLEL_SLAVE];
      nxt_sel_a[POS_CONVERTER_DONE] = wr_view_a[POS_CONVERTER_DONE];
      nxt_sel_a[POS_SERIAL_RX]      = wr_view_a[POS_SERIAL_RX];
      nxt_sel_a[POS_SERIAL_TX]      = wr_view_a[POS_SERIAL_TX];
      nxt_sel_a[POS_SYNC_SERIAL]    = wr_view_a[POS_SYNC_SERIAL];
      nxt_sel_a[POS_CAPTURE_A]      = wr_view_a[POS_CAPTURE_A];
      nxt_sel_a[POS_TIMER2_MATCH]   = wr_view_a[POS_TIMER2_MATCH];
      nxt_sel_a[POS_TIMER1_OVF]     = wr_view_a[POS_TIMER1_OVF];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_a_ff[POS_PARALLEL_SLAVE] <= RESET_SEL_A[POS_PARALLEL_SLAVE];
      sel_a_ff[POS_CONVERTER_DONE] <= RESET_SEL_A[POS_CONVERTER_DONE];
      sel_a_ff[POS_SERIAL_RX]      <= RESET_SEL_A[POS_SERIAL_RX];
      sel_a_ff[POS_SERIAL_TX]      <= RESET_SEL_A[POS_SERIAL_TX];
      sel_a_ff[POS_SYNC_SERIAL]    <= RESET_SEL_A[POS_SYNC_SERIAL];
      sel_a_ff[POS_CAPTURE_A]      <= RESET_SEL_A[POS_CAPTURE_A];
      sel_a_ff[POS_TIMER2_MATCH]   <= RESET_SEL_A[POS_TIMER2_MATCH];
      sel_a_ff[POS_TIMER1_OVF]     <= RESET_SEL_A[POS_TIMER1_OVF];
    end else begin
      sel_a_ff[POS_PARALLEL_SLAVE] <= nxt_sel_a[POS_PARALLEL_SLAVE];
      sel_a_ff[POS_CONVERTER_DONE] <= nxt_sel_a[POS_CONVERTER_DONE];
      sel_a_ff[POS_SERIAL_RX]      <= nxt_sel_a[POS_SERIAL_RX];
      sel_a_ff[POS_SERIAL_TX]      <= nxt_sel_a[POS_SERIAL_TX];
      sel_a_ff[POS_SYNC_SERIAL]    <= nxt_sel_a[POS_SYNC_SERIAL];
      sel_a_ff[POS_CAPTURE_A]      <= nxt_sel_a[POS_CAPTURE_A];
      sel_a_ff[POS_TIMER2_MATCH]   <= nxt_sel_a[POS_TIMER2_MATCH];
      sel_a_ff[POS_TIMER1_OVF]     <= nxt_sel_a[POS_TIMER1_OVF];
    end
  end

  // Register b: positions seven, five and four hold constant zero
  always_comb begin
    nxt_sel_b = sel_b_ff;
    if (wr_b) begin
      nxt_sel_b[POS_COMPARATOR]    = wr_view_b[POS_COMPARATOR];
      nxt_sel_b[POS_BUS_COLLISION] = wr_view_b[POS_BUS_COLLISION];
      nxt_sel_b[POS_LOW_VOLTAGE]   = wr_view_b[POS_LOW_VOLTAGE];
      nxt_sel_b[POS_TIMER3_OVF]    = wr_view_b[POS_TIMER3_OVF];
      nxt_sel_b[POS_CAPTURE_B]     = wr_view_b[POS_CAPTURE_B];
    end
    nxt_sel_b[7] = 1'b0;
    nxt_sel_b[5] = 1'b0;
    nxt_sel_b[4] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_b_ff[POS_COMPARATOR]    <= RESET_SEL_B[POS_COMPARATOR];
      sel_b_ff[POS_BUS_COLLISION] <= RESET_SEL_B[POS_BUS_COLLISION];
      sel_b_ff[POS_LOW_VOLTAGE]   <= RESET_SEL_B[POS_LOW_VOLTAGE];
      sel_b_ff[POS_TIMER3_OVF]    <= RESET_SEL_B[POS_TIMER3_OVF];
      sel_b_ff[POS_CAPTURE_B]     <= RESET_SEL_B[POS_CAPTURE_B];
      sel_b_ff[7]                 <= 1'b0;
      sel_b_ff[5]                 <= 1'b0;
      sel_b_ff[4]                 <= 1'b0;
    end else begin
      sel_b_ff[POS_COMPARATOR]    <= nxt_sel_b[POS_COMPARATOR];
      sel_b_ff[POS_BUS_COLLISION] <= nxt_sel_b[POS_BUS_COLLISION];
      sel_b_ff[POS_LOW_VOLTAGE]   <= nxt_sel_b[POS_LOW_VOLTAGE];
      sel_b_ff[POS_TIMER3_OVF]    <= nxt_sel_b[POS_TIMER3_OVF];
      sel_b_ff[POS_CAPTURE_B]     <= nxt_sel_b[POS_CAPTURE_B];
      sel_b_ff[7]                 <= nxt_sel_b[7];
      sel_b_ff[5]                 <= nxt_sel_b[5];
      sel_b_ff[4]                 <= nxt_sel_b[4];
    end
  end

  // Register c: all eight bits implemented
  always_comb begin
    nxt_sel_c = sel_c_ff;
    if (wr_c) begin
      nxt_sel_c[POS_INVALID_MSG] = wr_view_c[POS_INVALID_MSG];
      nxt_sel_c[POS_BUS_WAKEUP]  = wr_view_c[POS_BUS_WAKEUP];
      nxt_sel_c[POS_CAN_ERROR]   = wr_view_c[POS_CAN_ERROR];
      nxt_sel_c[POS_TX_BUF_TWO]  = wr_view_c[POS_TX_BUF_TWO];
      nxt_sel_c[POS_TX_BUF_ONE]  = wr_view_c[POS_TX_BUF_ONE];
      nxt_sel_c[POS_TX_BUF_ZERO] = wr_view_c[POS_TX_BUF_ZERO];
      nxt_sel_c[POS_RX_BUF_ONE]  = wr_view_c[POS_RX_BUF_ONE];
      nxt_sel_c[POS_RX_BUF_ZERO] = wr_view_c[POS_RX_BUF_ZERO];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_c_ff[POS_INVALID_MSG] <= RESET_SEL_C[POS_INVALID_MSG];
      sel_c_ff[POS_BUS_WAKEUP]  <= RESET_SEL_C[POS_BUS_WAKEUP];
      sel_c_ff[POS_CAN_ERROR]   <= RESET_SEL_C[POS_CAN_ERROR];
      sel_c_ff[POS_TX_BUF_TWO]  <= RESET_SEL_C[POS_TX_BUF_TWO];
      sel_c_ff[POS_TX_BUF_ONE]  <= RESET_SEL_C[POS_TX_BUF_ONE];
      sel_c_ff[POS_TX_BUF_ZERO] <= RESET_SEL_C[POS_TX_BUF_ZERO];
      sel_c_ff[POS_RX_BUF_ONE]  <= RESET_SEL_C[POS_RX_BUF_ONE];
      sel_c_ff[POS_RX_BUF_ZERO] <= RESET_SEL_C[POS_RX_BUF_ZERO];
    end else begin
      sel_c_ff[POS_INVALID_MSG] <= nxt_sel_c[POS_INVALID_MSG];
      sel_c_ff[POS_BUS_WAKEUP]  <= nxt_sel_c[POS_BUS_WAKEUP];
      sel_c_ff[POS_CAN_ERROR]   <= nxt_sel_c[POS_CAN_ERROR];
      sel_c_ff[POS_TX_BUF_TWO]  <= nxt_sel_c[POS_TX_BUF_TWO];
      sel_c_ff[POS_TX_BUF_ONE]  <= nxt_sel_c[POS_TX_BUF_ONE];
      sel_c_ff[POS_TX_BUF_ZERO] <= nxt_sel_c[POS_TX_BUF_ZERO];
      sel_c_ff[POS_RX_BUF_ONE]  <= nxt_sel_c[POS_RX_BUF_ONE];
      sel_c_ff[POS_RX_BUF_ZERO] <= nxt_sel_c[POS_RX_BUF_ZERO];
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  // Zero when idle keeps stale values off the shared read bus
  always_comb begin
    nxt_rd_data = READ_UNMAPPED;

    if (rd_a) begin
      nxt_rd_data[POS_PARALLEL_SLAVE] = view_a[POS_PARALLEL_SLAVE];
      nxt_rd_data[POS_CONVERTER_DONE] = view_a[POS_CONVERTER_DONE];
      nxt_rd_data[POS_SERIAL_RX]      = view_a[POS_SERIAL_RX];
      nxt_rd_data[POS_SERIAL_TX]      = view_a[POS_SERIAL_TX];
      nxt_rd_data[POS_SYNC_SERIAL]    = view_a[POS_SYNC_SERIAL];
      nxt_rd_data[POS_CAPTURE_A]      = view_a[POS_CAPTURE_A];
      nxt_rd_data[POS_TIMER2_MATCH]   = view_a[POS_TIMER2_MATCH];
      nxt_rd_data[POS_TIMER1_OVF]     = view_a[POS_TIMER1_OVF];
    end

    if (rd_b) begin
      nxt_rd_data[7]                  = 1'b0;
      nxt_rd_data[POS_COMPARATOR]     = view_b[POS_COMPARATOR];
      nxt_rd_data[5]                  = 1'b0;
      nxt_rd_data[4]                  = 1'b0;
      nxt_rd_data[POS_BUS_COLLISION]  = view_b[POS_BUS_COLLISION];
      nxt_rd_data[POS_LOW_VOLTAGE]    = view_b[POS_LOW_VOLTAGE];
      nxt_rd_data[POS_TIMER3_OVF]     = view_b[POS_TIMER3_OVF];
      nxt_rd_data[POS_CAPTURE_B]      = view_b[POS_CAPTURE_B];
    end

    if (rd_c) begin
      nxt_rd_data[POS_INVALID_MSG]    = view_c[POS_INVALID_MSG];
      nxt_rd_data[POS_BUS_WAKEUP]     = view_c[POS_BUS_WAKEUP];
      nxt_rd_data[POS_CAN_ERROR]      = view_c[POS_CAN_ERROR];
      nxt_rd_data[POS_TX_BUF_TWO]     = view_c[POS_TX_BUF_TWO];
      nxt_rd_data[POS_TX_BUF_ONE]     = view_c[POS_TX_BUF_ONE];
      nxt_rd_data[POS_TX_BUF_ZERO]    = view_c[POS_TX_BUF_ZERO];
      nxt_rd_data[POS_RX_BUF_ONE]     = view_c[POS_RX_BUF_ONE];
      nxt_rd_data[POS_RX_BUF_ZERO]    = view_c[POS_RX_BUF_ZERO];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_ff <= READ_UNMAPPED;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;

  // Levels straight from the flops, so no extra cycle after a write
  // Register a sources
  always_comb begin
    parallel_slave_level  = sel_a_ff[POS_PARALLEL_SLAVE];
    converter_done_level  = sel_a_ff[POS_CONVERTER_DONE];
    serial_rx_level       = sel_a_ff[POS_SERIAL_RX];
    serial_tx_level       = sel_a_ff[POS_SERIAL_TX];
    sync_serial_level     = sel_a_ff[POS_SYNC_SERIAL];
    capture_unit_a_level  = sel_a_ff[POS_CAPTURE_A];
    timer2_match_level    = sel_a_ff[POS_TIMER2_MATCH];
    timer1_overflow_level = sel_a_ff[POS_TIMER1_OVF];
  end

  // Register b sources
  always_comb begin
    comparator_level      = sel_b_ff[POS_COMPARATOR];
    bus_collision_level   = sel_b_ff[POS_BUS_COLLISION];
    low_voltage_level     = sel_b_ff[POS_LOW_VOLTAGE];
    timer3_overflow_level = sel_b_ff[POS_TIMER3_OVF];
    capture_unit_b_level  = sel_b_ff[POS_CAPTURE_B];
  end

  // Register c sources, all from the bus controller
  always_comb begin
    invalid_message_level = sel_c_ff[POS_INVALID_MSG];
    bus_wakeup_level      = sel_c_ff[POS_BUS_WAKEUP];
    can_error_level       = sel_c_ff[POS_CAN_ERROR];
    tx_buffer_two_level   = sel_c_ff[POS_TX_BUF_TWO];
    tx_buffer_one_level   = sel_c_ff[POS_TX_BUF_ONE];
    tx_buffer_zero_level  = sel_c_ff[POS_TX_BUF_ZERO];
    rx_buffer_one_level   = sel_c_ff[POS_RX_BUF_ONE];
    rx_buffer_zero_level  = sel_c_ff[POS_RX_BUF_ZERO];
  end

endmodule : interrupt_priority_select_bank

// [logic/priority_select_pkg.sv]
// Package: register map, field positions and reset values of the priority bank
package priority_select_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register indices
  localparam logic [3:0] ADDR_SEL_A = 4'h0;
  localparam logic [3:0] ADDR_SEL_B = 4'h1;
  localparam logic [3:0] ADDR_SEL_C = 4'h2;

  // Implemented-bit masks and reset values
  localparam logic [7:0] MASK_SEL_A  = 8'hff;
  localparam logic [7:0] MASK_SEL_B  = 8'h4f;
  localparam logic [7:0] MASK_SEL_C  = 8'hff;
  localparam logic [7:0] RESET_SEL_A = 8'hff;
  localparam logic [7:0] RESET_SEL_B = 8'h4f;
  localparam logic [7:0] RESET_SEL_C = 8'hff;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Field positions, register a
  localparam int POS_PARALLEL_SLAVE = 7;
  localparam int POS_CONVERTER_DONE = 6;
  localparam int POS_SERIAL_RX      = 5;
  localparam int POS_SERIAL_TX      = 4;
  localparam int POS_SYNC_SERIAL    = 3;
  localparam int POS_CAPTURE_A      = 2;
  localparam int POS_TIMER2_MATCH   = 1;
  localparam int POS_TIMER1_OVF     = 0;
  // Register b
  localparam int POS_COMPARATOR     = 6;
  localparam int POS_BUS_COLLISION  = 3;
  localparam int POS_LOW_VOLTAGE    = 2;
  localparam int POS_TIMER3_OVF     = 1;
  localparam int POS_CAPTURE_B      = 0;
  // Register c
  localparam int POS_INVALID_MSG    = 7;
  localparam int POS_BUS_WAKEUP     = 6;
  localparam int POS_CAN_ERROR      = 5;
  localparam int POS_TX_BUF_TWO     = 4;
  localparam int POS_TX_BUF_ONE     = 3;
  localparam int POS_TX_BUF_ZERO    = 2;
  localparam int POS_RX_BUF_ONE     = 1;
  localparam int POS_RX_BUF_ZERO    = 0;

endpackage : priority_select_pkg

// [verification/interrupt_priority_select_bank_properties.sv]
// Checker for the priority bank bus and level outputs
`timescale 1ns/1ps
module interrupt_priority_select_bank_properties import priority_select_pkg::*; (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_strobe,
  input wire logic              rd_strobe,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              converter_done_level,
  input wire logic              comparator_level,
  input wire logic              rx_buffer_zero_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr_b; wr_strobe && addr == ADDR_SEL_B; endsequence
  sequence s_rd_b; rd_strobe && addr == ADDR_SEL_B; endsequence
  // Reset is seen even while held low
  property p_reset; disable iff (1'b0) !reset_n |=> rd_data == 8'h00
    && converter_done_level && comparator_level && rx_buffer_zero_level; endproperty
  property p_mask; s_rd_b |=> rd_data[7] == 1'b0 && rd_data[5:4] == 2'h0; endproperty
  property p_conv; wr_strobe && addr == ADDR_SEL_A |=> converter_done_level == $past(wr_data[6]);
  endproperty
  property p_cmp; s_wr_b |=> comparator_level == $past(wr_data[6]); endproperty
  property p_rxb0; wr_strobe && addr == ADDR_SEL_C |=> rx_buffer_zero_level == $past(wr_data[0]);
  endproperty
  property p_rd_a; rd_strobe && addr == ADDR_SEL_A |=> rd_data[6] == $past(converter_done_level);
  endproperty
  property p_hold; !wr_strobe |=> $stable(converter_done_level); endproperty
  property p_wr_rd_b; s_wr_b ##1 s_rd_b |=> rd_data == ($past(wr_data, 2) & 8'h4f); endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_mask: assert property (p_mask) else $error("unused bits of b not zero");
  a_conv: assert property (p_conv) else $error("converter level wrong");
  a_cmp: assert property (p_cmp) else $error("comparator level wrong");
  a_rxb0: assert property (p_rxb0) else $error("receive buffer zero level wrong");
  a_rd_a: assert property (p_rd_a) else $error("read of a disagrees with level");
  a_hold: assert property (p_hold) else $error("level moved without write");
  a_wr_rd_b: assert property (p_wr_rd_b) else $error("b readback wrong");
endmodule : interrupt_priority_select_bank_properties
bind interrupt_priority_select_bank interrupt_priority_select_bank_properties chk_i (.*);

// [verification/testbench.sv]
// Testbench for the interrupt priority select bank
`timescale 1ns/1ps
module testbench import priority_select_pkg::*; ;
  logic       clk = 1'b0, reset_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00, rd_data, la, lb, lc;
  logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
  int         failures = 0, checks_done = 0;
  always #5 clk = ~clk;
  assign {lb[7], lb[5:4]} = 3'h0;
  interrupt_priority_select_bank dut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .parallel_slave_level(la[7]), .converter_done_level(la[6]), .serial_rx_level(la[5]),
    .serial_tx_level(la[4]), .sync_serial_level(la[3]), .capture_unit_a_level(la[2]),
    .timer2_match_level(la[1]), .timer1_overflow_level(la[0]), .comparator_level(lb[6]),
    .bus_collision_level(lb[3]), .low_voltage_level(lb[2]), .timer3_overflow_level(lb[1]),
    .capture_unit_b_level(lb[0]), .invalid_message_level(lc[7]), .bus_wakeup_level(lc[6]),
    .can_error_level(lc[5]), .tx_buffer_two_level(lc[4]), .tx_buffer_one_level(lc[3]),
    .tx_buffer_zero_level(lc[2]), .rx_buffer_one_level(lc[1]), .rx_buffer_zero_level(lc[0]));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Write then read in the next cycle, so the read sees the new value
  task automatic wr_rd(logic [3:0] a, logic [7:0] d, logic [7:0] e, string n);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 chk(n, e, rd_data);
    @(posedge clk);
  endtask : wr_rd
  // Data valid only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [7:0] e, string n);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 chk(n, e, rd_data);
    @(posedge clk);
  endtask : rd
  // Reads b first, so after wr_rd of b the next read is again of b
  task automatic rd_all(logic [7:0] a, logic [7:0] b, logic [7:0] c);
    rd(ADDR_SEL_B, b, "reg b");
    chk("levels b", b, lb);
    rd(ADDR_SEL_A, a, "reg a");
    chk("levels a", a, la);
    rd(ADDR_SEL_C, c, "reg c");
    chk("levels c", c, lc);
    rd(4'h7, 8'h00, "unmapped");
  endtask : rd_all
  task automatic t_patterns();
    foreach (pat[i]) begin
      wr(ADDR_SEL_A, pat[i]);
      wr(ADDR_SEL_C, pat[i]);
      wr(4'h9, ~pat[i]);
      wr_rd(ADDR_SEL_B, pat[i], pat[i] & 8'h4f, "reg b after write");
      rd_all(pat[i], pat[i] & 8'h4f, pat[i]);
    end
    $display("test patterns done");
  endtask : t_patterns
  // Second reset after the registers were last written with 8'haa
  task automatic t_midreset();
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    rd_all(8'hff, 8'h4f, 8'hff);
    $display("test midreset done");
  endtask : t_midreset
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd_all(8'hff, 8'h4f, 8'hff);
    $display("test reset done");
    t_patterns();
    t_midreset();
    stop_test();
  end
endmodule : testbench
